// file: src/smc_defs.svh
// Constants for the supply monitor channel block.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// ==========================================================================
// Clock and channel count
`define SMC_CLK_MHZ 125
`define SMC_NCH 7
`define SMC_LVL_W 8

// ==========================================================================
// Register indices (byte address is four times the index)
`define SMC_IDX_BASE 10'h0A0
`define SMC_IDX_STATUS 10'h0D8
`define SMC_NFLD 3'h5
`define SMC_FLD_OVTH 3'h0
`define SMC_FLD_OVHY 3'h1
`define SMC_FLD_UVTH 3'h2
`define SMC_FLD_UVHY 3'h3
`define SMC_FLD_SEL 3'h4

// ==========================================================================
// Reset values
`define SMC_RST_OVTH 8'hFF
`define SMC_RST_HYST 5'h00
`define SMC_RST_UVTH 8'h00
`define SMC_RST_SEL 8'h00

// ==========================================================================
// Select register fields
`define SMC_SEL_POL 7
`define SMC_SEL_GF 6:4
`define SMC_SEL_RNG 3:2
`define SMC_SEL_TYPE 1:0
`define SMC_TYPE_UV 2'h0
`define SMC_TYPE_OV 2'h1
`define SMC_RNGF_MID 2'h0
`define SMC_RNGF_ALT 2'h1
`define SMC_RNGF_ULOW 2'h2

// ==========================================================================
// Glitch filter delays in microseconds, one per code
`define SMC_GF_US0 0
`define SMC_GF_US1 5
`define SMC_GF_US2 10
`define SMC_GF_US3 20
`define SMC_GF_US4 30
`define SMC_GF_US5 50
`define SMC_GF_US6 75
`define SMC_GF_US7 100
`define SMC_GF_CW 20

`endif

// file: src/smc_pkg.sv
// Types shared by the supply monitor channel block.
package smc_pkg;

  // ========================================================================
  // Detection ranges driven to the analog divider
  typedef enum logic [2:0] {
    SMC_RNG_ULOW, SMC_RNG_LOW, SMC_RNG_MID, SMC_RNG_HIGH, SMC_RNG_NEG
  } smc_range_t;

  typedef enum logic [1:0] {SMC_KIND_HV, SMC_KIND_BIP, SMC_KIND_POS} smc_kind_t;

  // ========================================================================
  // Per-channel configuration and status
  typedef struct packed {
    logic [7:0] ovth;
    logic [4:0] ovhy;
    logic [7:0] uvth;
    logic [4:0] uvhy;
    logic [7:0] sel;
  } smc_cfg_t;

  typedef struct packed {
    logic uv;
    logic ov;
    logic fault;
  } smc_stat_t;

  typedef struct packed {
    logic hit;
    logic stat;
    logic [2:0] ch;
    logic [2:0] fld;
  } smc_dec_t;

endpackage

// file: src/smc_chan.sv
// One supply monitor channel: comparison, hysteresis, fault type, filter.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_chan #(
  parameter smc_pkg::smc_kind_t KIND = smc_pkg::SMC_KIND_POS,
  parameter int unsigned CYC_PER_US = `SMC_CLK_MHZ
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Configuration and synchronised level code
  input smc_pkg::smc_cfg_t cfg,
  input wire logic [`SMC_LVL_W-1:0] level,
  // Results
  output smc_pkg::smc_stat_t stat_q,
  output smc_pkg::smc_range_t range_q
);
  import smc_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [4:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {4'h0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [7:0] sat_sub(input logic [7:0] a,
                                         input logic [4:0] b);
    logic [8:0] s;
    s = {1'b0, a} - {4'h0, b};
    return s[8] ? 8'h00 : s[7:0];
  endfunction

  function automatic int unsigned gf_us(input logic [2:0] code);
    unique case (code)
      3'h0: return `SMC_GF_US0;
      3'h1: return `SMC_GF_US1;
      3'h2: return `SMC_GF_US2;
      3'h3: return `SMC_GF_US3;
      3'h4: return `SMC_GF_US4;
      3'h5: return `SMC_GF_US5;
      3'h6: return `SMC_GF_US6;
      3'h7: return `SMC_GF_US7;
    endcase
  endfunction

  function automatic smc_range_t map_range(input logic [7:0] sel);
    if (KIND == SMC_KIND_BIP && sel[`SMC_SEL_POL]) begin
      return SMC_RNG_NEG;
    end
    unique case (sel[`SMC_SEL_RNG])
      `SMC_RNGF_ALT: return (KIND == SMC_KIND_HV) ? SMC_RNG_HIGH : SMC_RNG_LOW;
      `SMC_RNGF_ULOW: return (KIND == SMC_KIND_POS) ? SMC_RNG_ULOW : SMC_RNG_MID;
      default: return SMC_RNG_MID;
    endcase
  endfunction

  // ========================================================================
  // Comparators with hysteresis
  logic uv_q;
  logic ov_q;
  logic filt_q;
  logic [7:0] uv_eff;
  logic [7:0] ov_eff;
  logic raw;
  logic [`SMC_GF_CW-1:0] cnt_q;
  logic [`SMC_GF_CW-1:0] n_cyc;

  // Hysteresis moves the threshold only while the fault is active.
  assign uv_eff = uv_q ? sat_add(cfg.uvth, cfg.uvhy) : cfg.uvth;
  assign ov_eff = ov_q ? sat_sub(cfg.ovth, cfg.ovhy) : cfg.ovth;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q <= 1'b0;
    end else if (ce) begin
      uv_q <= level < uv_eff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q <= 1'b0;
    end else if (ce) begin
      ov_q <= level > ov_eff;
    end
  end

  // One fault type drives the single fault result.
  always_comb begin
    unique case (cfg.sel[`SMC_SEL_TYPE])
      `SMC_TYPE_UV: raw = uv_q;
      `SMC_TYPE_OV: raw = ov_q;
      default: raw = uv_q | ov_q;
    endcase
  end

  // ========================================================================
  // Glitch filter; a zero delay still costs the output register's cycle.
  assign n_cyc = `SMC_GF_CW'(gf_us(cfg.sel[`SMC_SEL_GF]) * CYC_PER_US);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (ce) begin
      if (raw == filt_q) begin
        cnt_q <= '0;
      end else if (cnt_q + 1'b1 >= n_cyc) begin
        cnt_q <= '0;
        filt_q <= raw;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q <= SMC_RNG_MID;
    end else if (ce) begin
      range_q <= map_range(cfg.sel);
    end
  end

  assign stat_q = '{uv: uv_q, ov: ov_q, fault: filt_q};

  // ========================================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uv_hyst_hold: assert property (
    ce && uv_q && level < sat_add(cfg.uvth, cfg.uvhy) |=> uv_q)
    else $error("UV fault released inside hysteresis band");
  a_ov_hyst_hold: assert property (
    ce && ov_q && level > sat_sub(cfg.ovth, cfg.ovhy) |=> ov_q)
    else $error("OV fault released inside hysteresis band");
  a_uv_assert_now: assert property (
    ce && level < cfg.uvth |=> uv_q)
    else $error("UV not flagged below threshold");
  a_gf_short_held: assert property (
    ce && raw != filt_q && cnt_q + 1'b1 < n_cyc |=> $stable(filt_q))
    else $error("Filter passed a change before its timeout");
  a_gf_long_pass: assert property (
    ce && raw != filt_q && cnt_q + 1'b1 >= n_cyc |=> filt_q == $past(raw))
    else $error("Filter failed to pass a change at its timeout");
  a_neg_range_only: assert property (
    ce && KIND == SMC_KIND_BIP && cfg.sel[`SMC_SEL_POL]
    |=> range_q == SMC_RNG_NEG)
    else $error("Negative mode did not force negative range");
  c_uv_fault: cover property ($rose(filt_q) && uv_q);
  c_ov_fault: cover property ($rose(filt_q) && ov_q);
  c_glitch_hidden: cover property (raw != filt_q ##1 raw == filt_q);

endmodule // smc_chan

// file: src/smc_top.sv
// Seven supply monitor channels with APB configuration registers.
//
// Function
// - Seven independent channels: one high-voltage, two bipolar, four positive.
// - Each channel has exactly one fault output of one selected type; the block also outputs each channel's unfiltered UV and OV flags.
// - Supply below UV threshold sets UV; above OV threshold sets OV.
// - Each channel holds 8-bit UV and OV threshold codes.
// - Every range spans from one third of its top to its top.
// - Range choices depend on the channel kind.
// - Hysteresis settings are separate, five bits wide, upper bits unused.
// - Active UV clears only above threshold plus UV hysteresis.
// - Active OV clears only below threshold minus OV hysteresis.
// - Hysteresis counts in the same code steps as the threshold.
// - Bipolar select bit 7 picks positive or negative input.
// - Negative mode allows only the minus six to minus two range.
// - Select bits 1:0 pick UV, OV or out-of-window fault.
// - The last stage is a glitch filter of up to 100 us.
// - Changes shorter than the timeout never reach the output.
// - Longer changes pass, delayed by exactly the timeout.
// - Host sets thresholds, hysteresis, filter and type per channel.
// - OV thresholds reset to 0xFF, all other settings to zero.
// - Select bits 6:4 set filter delay; zero none, one gives 5 us.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_top #(
  parameter int unsigned CYC_PER_US = `SMC_CLK_MHZ
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Digitised supply level codes, one per channel, from the analog side
  input wire logic [`SMC_NCH-1:0][`SMC_LVL_W-1:0] level_i,
  // Channel results
  output smc_pkg::smc_stat_t [`SMC_NCH-1:0] stat_q,
  output smc_pkg::smc_range_t [`SMC_NCH-1:0] range_q
);
  import smc_pkg::*;

  // ========================================================================
  // Helpers
  localparam smc_cfg_t RST_CFG = '{
    ovth: `SMC_RST_OVTH, ovhy: `SMC_RST_HYST, uvth: `SMC_RST_UVTH,
    uvhy: `SMC_RST_HYST, sel: `SMC_RST_SEL};

  function automatic smc_dec_t decode(input logic [9:0] idx);
    smc_dec_t d;
    logic [9:0] rel;
    d = '0;
    rel = idx - `SMC_IDX_BASE;
    d.stat = (idx == `SMC_IDX_STATUS);
    if (idx >= `SMC_IDX_BASE && rel[9:3] < 7'(`SMC_NCH) &&
        rel[2:0] < `SMC_NFLD) begin
      d.hit = 1'b1;
      d.ch = rel[5:3];
      d.fld = rel[2:0];
    end
    return d;
  endfunction

  // Hysteresis fields read back with their unused upper bits as zero.
  function automatic logic [31:0] rd_cfg(input smc_cfg_t c,
                                         input logic [2:0] fld);
    unique case (fld)
      `SMC_FLD_OVTH: return {24'h000000, c.ovth};
      `SMC_FLD_OVHY: return {27'h0000000, c.ovhy};
      `SMC_FLD_UVTH: return {24'h000000, c.uvth};
      `SMC_FLD_UVHY: return {27'h0000000, c.uvhy};
      default: return {24'h000000, c.sel};
    endcase
  endfunction

  // ========================================================================
  // APB decode
  smc_cfg_t [`SMC_NCH-1:0] cfg_q;
  smc_dec_t dec;
  logic setup;
  logic wr_en;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic any_wr_q;

  assign dec = decode(paddr[11:2]);
  assign setup = psel && !penable && !pready_q;
  // A write lands at the access edge; the status word is read-only.
  assign wr_en = psel && penable && pready_q && pwrite && dec.hit;

  // Every access takes one wait-free access cycle after its setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pslverr_q <= setup && !dec.hit && !dec.stat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (ce && setup) begin
      if (pwrite || !(dec.hit || dec.stat)) begin
        prdata_q <= 32'h00000000;
      end else if (dec.stat) begin
        prdata_q <= {11'h000, stat_fault(), stat_ov(), stat_uv()};
      end else begin
        prdata_q <= rd_cfg(cfg_q[dec.ch], dec.fld);
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  function automatic logic [`SMC_NCH-1:0] stat_fault();
    logic [`SMC_NCH-1:0] v;
    v = '0;
    for (int i = 0; i < `SMC_NCH; i++) begin
      v[i] = stat_q[i].fault;
    end
    return v;
  endfunction

  function automatic logic [`SMC_NCH-1:0] stat_ov();
    logic [`SMC_NCH-1:0] v;
    v = '0;
    for (int i = 0; i < `SMC_NCH; i++) begin
      v[i] = stat_q[i].ov;
    end
    return v;
  endfunction

  function automatic logic [`SMC_NCH-1:0] stat_uv();
    logic [`SMC_NCH-1:0] v;
    v = '0;
    for (int i = 0; i < `SMC_NCH; i++) begin
      v[i] = stat_q[i].uv;
    end
    return v;
  endfunction

  // ========================================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `SMC_NCH; i++) begin
        cfg_q[i] <= RST_CFG;
      end
    end else if (ce && wr_en) begin
      unique case (dec.fld)
        `SMC_FLD_OVTH: cfg_q[dec.ch].ovth <= pwdata[7:0];
        `SMC_FLD_OVHY: cfg_q[dec.ch].ovhy <= pwdata[4:0];
        `SMC_FLD_UVTH: cfg_q[dec.ch].uvth <= pwdata[7:0];
        `SMC_FLD_UVHY: cfg_q[dec.ch].uvhy <= pwdata[4:0];
        default: cfg_q[dec.ch].sel <= pwdata[7:0];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_wr_q <= 1'b0;
    end else if (ce && wr_en) begin
      any_wr_q <= 1'b1;
    end
  end

  // ========================================================================
  // Level synchronisers
  // The level code comes from another domain; a code that moves during
  // sampling may be seen one step late or early, which hysteresis absorbs.
  logic [`SMC_NCH-1:0][`SMC_LVL_W-1:0] lvl_s1_q;
  logic [`SMC_NCH-1:0][`SMC_LVL_W-1:0] lvl_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_s1_q <= '0;
      lvl_s2_q <= '0;
    end else if (ce) begin
      lvl_s1_q <= level_i;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // ========================================================================
  // Channels: 0 and 1 bipolar, 2 high-voltage, 3 to 6 positive-only
  for (genvar g = 0; g < `SMC_NCH; g++) begin : g_chan
    localparam smc_kind_t KIND = (g < 2) ? SMC_KIND_BIP :
                                 (g == 2) ? SMC_KIND_HV : SMC_KIND_POS;
    smc_chan #(
      .KIND(KIND),
      .CYC_PER_US(CYC_PER_US)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .cfg(cfg_q[g]),
      .level(lvl_s2_q[g]),
      .stat_q(stat_q[g]),
      .range_q(range_q[g])
    );
  end

  // ========================================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_ready_next: assert property (
    ce && setup |=> pready && !(ce && setup))
    else $error("Setup cycle not answered in the next cycle");
  a_cfg_write_take: assert property (
    ce && wr_en && dec.fld == `SMC_FLD_UVTH
    |=> cfg_q[$past(dec.ch)].uvth == $past(pwdata[7:0]))
    else $error("UV threshold write not stored");
  a_hyst_read_zero: assert property (
    ce && setup && !pwrite && dec.hit &&
    (dec.fld == `SMC_FLD_OVHY || dec.fld == `SMC_FLD_UVHY)
    |=> prdata[31:5] == 27'h0000000)
    else $error("Hysteresis readback has upper bits set");
  a_ov_default_ff: assert property (
    !any_wr_q |-> cfg_q[3].ovth == `SMC_RST_OVTH &&
    cfg_q[3].sel == `SMC_RST_SEL)
    else $error("Untouched channel lost its reset settings");
  a_bad_addr_err: assert property (
    ce && setup && !dec.hit && !dec.stat |=> pslverr && pready)
    else $error("Unmapped address not flagged");
  c_apb_write: cover property (ce && wr_en);
  c_status_read: cover property (ce && setup && dec.stat && !pwrite);

endmodule // smc_top

// file: verification/smc_supply_model.sv
// Analog front end model: digitises each supply into a level code.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_supply_model (
  // Clock
  input wire logic pclk,
  // Supply codes and routing of supply three onto channel four
  input wire logic [`SMC_NCH-1:0][7:0] supply,
  input wire logic share,
  // Level codes toward the block
  output logic [`SMC_NCH-1:0][7:0] level
);
  // One sample per clock, as a converter would deliver it.
  always_ff @(posedge pclk) begin
    for (int c = 0; c < `SMC_NCH; c++) begin
      level[c] <= supply[c];
    end
    // A second channel watches the same supply for the other fault kind.
    if (share) begin
      level[4] <= supply[3];
    end
  end
endmodule // smc_supply_model

// file: verification/smc_top_test.sv
// Self-checking testbench for the supply monitor channel block.
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_top_test;
  import smc_pkg::*;
  localparam int CPU = 1;
  // The host's code for a 5 V limit on the 2 V to 6 V range.
  localparam int OV5 = int'(255.0 * (5.0 - 2.005) / 3.997);
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, seed = 32'h5, st;
  logic pready, pslverr, rerr, share = 0;
  logic [`SMC_NCH-1:0][7:0] supply = '0, level;
  smc_stat_t [`SMC_NCH-1:0] stat_q;
  smc_range_t [`SMC_NCH-1:0] range_q;
  int num_errors = 0, comparisons = 0;
  logic [7:0] cfg [7][5];
  logic uv_e [7], ov_e [7], ft_e [7];

  smc_supply_model model (.pclk(pclk), .supply(supply), .share(share),
    .level(level));
  smc_top #(.CYC_PER_US(CPU)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .level_i(level), .stat_q(stat_q),
    .range_q(range_q));

  initial begin
    forever #4 pclk = ~pclk;
  end

  // ========================================================================
  // Helpers
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int dly(int g);
    int t [8] = '{`SMC_GF_US0, `SMC_GF_US1, `SMC_GF_US2, `SMC_GF_US3,
      `SMC_GF_US4, `SMC_GF_US5, `SMC_GF_US6, `SMC_GF_US7};
    return g == 0 ? 1 : t[g] * CPU;
  endfunction

  // Hysteresis moves the threshold only while its fault is held.
  function automatic void eval(int c);
    logic [8:0] l, ut, ot;
    l = (share && c == 4) ? supply[3] : supply[c];
    ut = uv_e[c] ? {1'b0, cfg[c][2]} + cfg[c][3] : {1'b0, cfg[c][2]};
    if (ut > 9'h0FF) ut = 9'h0FF;
    ot = ov_e[c] ? {1'b0, cfg[c][0]} - cfg[c][1] : {1'b0, cfg[c][0]};
    if (ot[8]) ot = 9'h000;
    uv_e[c] = l < ut;
    ov_e[c] = l > ot;
    case (cfg[c][4][1:0])
      2'h0: ft_e[c] = uv_e[c];
      2'h1: ft_e[c] = ov_e[c];
      default: ft_e[c] = uv_e[c] | ov_e[c];
    endcase
  endfunction

  function automatic smc_range_t rexp(int c, logic [7:0] s);
    if (c < 2 && s[7]) return SMC_RNG_NEG;
    if (s[3:2] == 2'h1) return c == 2 ? SMC_RNG_HIGH : SMC_RNG_LOW;
    if (s[3:2] == 2'h2 && c > 2) return SMC_RNG_ULOW;
    return SMC_RNG_MID;
  endfunction

  function automatic logic [9:0] idx(int c, int f);
    return `SMC_IDX_BASE + 10'(8 * c + f);
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task end_sim();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ========================================================================
  // APB master
  task apb(input bit w, input logic [9:0] i, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input int c, input int f, input logic [7:0] d);
    apb(1, idx(c, f), {24'hFFFFFF, d});
    chk(rerr, 0);
    cfg[c][f] = (f == 1 || f == 3) ? d & 8'h1F : d;
    eval(c);
    apb(0, idx(c, f), 0);
    chk(rdat, {24'h0, cfg[c][f]});
  endtask

  task defaults();
    for (int c = 0; c < 7; c++) begin
      chk(stat_q[c], 0);
      chk(range_q[c], SMC_RNG_MID);
      uv_e[c] = 0;
      ov_e[c] = 0;
      for (int f = 0; f < 5; f++) begin
        cfg[c][f] = f == 0 ? `SMC_RST_OVTH : 8'h00;
        apb(0, idx(c, f), 0);
        chk(rdat, {24'h0, cfg[c][f]});
      end
    end
    apb(0, 10'h0A5, 0);
    chk(rerr, 1);
    chk(rdat, 0);
    apb(1, `SMC_IDX_STATUS, 32'hFFFFFFFF);
    chk(rerr, 0);
  endtask

  task wait_uv(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (stat_q[3].uv !== v && n < 20);
    chk(stat_q[3].uv, v);
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] v;
    int d;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    defaults();
    for (int s = 0; s < 60; s++) begin
      if (s % 10 == 0) begin
        for (int c = 0; c < 7; c++) begin
          for (int f = 0; f < 5; f++) begin
            r = nxt();
            wr(c, f, f == 4 ? {r[7], 3'h0, r[3:0]} : r[7:0]);
          end
        end
      end
      @(posedge pclk);
      r = nxt();
      share <= r[0];
      for (int c = 0; c < 7; c++) begin
        r = nxt();
        case (r[2:0])
          3'h0: v = cfg[c][2] - 8'h01;
          3'h1: v = cfg[c][2];
          3'h2: v = cfg[c][2] + cfg[c][3];
          3'h3: v = cfg[c][0];
          3'h4: v = cfg[c][0] + 8'h01;
          3'h5: v = cfg[c][0] - cfg[c][1];
          default: v = r[15:8];
        endcase
        supply[c] <= v;
      end
      repeat (7) @(posedge pclk);
      @(negedge pclk);
      st = 0;
      for (int c = 0; c < 7; c++) begin
        eval(c);
        st[c] = uv_e[c];
        st[7 + c] = ov_e[c];
        st[14 + c] = ft_e[c];
        chk(stat_q[c], {uv_e[c], ov_e[c], ft_e[c]});
        chk(range_q[c], rexp(c, cfg[c][4]));
      end
      apb(0, `SMC_IDX_STATUS, 0);
      chk(rdat, st);
    end
    // Glitch filter on channel three, every delay code.
    @(posedge pclk);
    share <= 0;
    supply[3] <= 8'hA0;
    wr(3, 0, 8'(OV5));
    wr(3, 1, 0);
    wr(3, 2, 8'h80);
    wr(3, 3, 0);
    for (int g = 0; g < 8; g++) begin
      d = dly(g);
      wr(3, 4, {1'b0, 3'(g), 4'h0});
      repeat (d + 8) @(posedge pclk);
      supply[3] <= 8'h70;
      wait_uv(1);
      repeat (d - 1) begin
        @(negedge pclk);
        chk(stat_q[3].fault, 0);
      end
      @(negedge pclk);
      chk(stat_q[3].fault, 1);
      @(posedge pclk);
      supply[3] <= 8'hA0;
      repeat (d + 8) @(posedge pclk);
      if (d > 1) begin
        supply[3] <= 8'h70;
        repeat (d - 1) @(posedge pclk);
        supply[3] <= 8'hA0;
      end
      repeat (d + 8) begin
        @(negedge pclk);
        chk(stat_q[3].fault, 0);
      end
    end
    wr(3, 4, 8'h01);
    @(posedge pclk);
    supply[3] <= 8'(OV5 + 1);
    repeat (8) @(negedge pclk);
    chk(stat_q[3].fault, 1);
    // A low enable freezes every flop although the supply moves.
    @(posedge pclk);
    ce <= 0;
    supply[3] <= 8'h00;
    repeat (8) @(negedge pclk);
    chk(stat_q[3], {1'b0, 1'b1, 1'b1});
    @(posedge pclk);
    ce <= 1;
    repeat (8) @(negedge pclk);
    eval(3);
    chk(stat_q[3], {uv_e[3], ov_e[3], ft_e[3]});
    // A reset in mid-run brings every setting back.
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    defaults();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule // smc_top_test
